// >>> rtl/synth_serial_register_map.sv
`timescale 1ns/1ps
`default_nettype none
module synth_serial_register_map
    import synth_reg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic load_strobe,
    output divide_s divide_out,
    output phase_s phase_out,
    output refctl_s refctl_out,
    output bandclk_s bandclk_out,
    output outctl_s outctl_out,
    output lockpin_s lockpin_out,
    output logic divide_update
);
    logic [WORD_W-1:0] word;
    logic word_load;

    synth_serial_shifter #(.W(WORD_W)) u_shift (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .load_strobe(load_strobe),
        .word(word),
        .word_load(word_load)
    );

    // ****************************************
    // Decode
    // ****************************************
    logic [SEL_W-1:0] sel;
    logic ld0, ld1, ld2, ld3, ld4, ld5;
    assign sel = word[SEL_W-1:0];
    // Codes 110 and 111 match nothing, so no register moves
    assign ld0 = word_load && (sel == SEL_R0);
    assign ld1 = word_load && (sel == SEL_R1);
    assign ld2 = word_load && (sel == SEL_R2);
    assign ld3 = word_load && (sel == SEL_R3);
    assign ld4 = word_load && (sel == SEL_R4);
    assign ld5 = word_load && (sel == SEL_R5);

    // ****************************************
    // Pending (written) images
    // ****************************************
    phase_s phase_pend_q;
    refctl_s ref_pend_q;
    logic [2:0] odiv_pend_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_pend_q <= '0;
        end else if (ld1) begin
            phase_pend_q.phase_adjust_enable <= word[R1_PHADJ];
            phase_pend_q.prescaler_select <= word[R1_PRESC];
            phase_pend_q.phase_word <= word[R1_PHASE_LO +: 12];
            phase_pend_q.channel_denominator <= word[F_LO +: 12];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_pend_q <= '0;
        end else if (ld2) begin
            ref_pend_q.noise_mode <= word[R2_NOISE_LO +: 2];
            ref_pend_q.mux_select <= word[R2_MUX_LO +: 3];
            ref_pend_q.ref_doubler <= word[R2_DBL];
            ref_pend_q.reference_halver <= word[R2_HALF];
            ref_pend_q.ref_counter <= word[R2_RCNT_LO +: 10];
            ref_pend_q.divider_dbuf_enable <= word[R2_DBB_EN];
            ref_pend_q.cp_current <= word[R2_CP_LO +: 4];
            ref_pend_q.lock_cycle_count_select <= word[R2_LDCNT];
            ref_pend_q.lock_window_select <= word[R2_LDWIN];
            ref_pend_q.pd_polarity <= word[R2_POL];
            ref_pend_q.power_down <= word[R2_PD];
            ref_pend_q.cp_three_state <= word[R2_CP3S];
            ref_pend_q.counter_reset <= word[R2_CRST];
        end
    end

    // Taken on every register 4 write, even while unbuffered, so turning
    // buffering on later never applies a stale divider value
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            odiv_pend_q <= '0;
        end else if (ld4) begin
            odiv_pend_q <= word[R4_ODIV_LO +: 3];
        end
    end

    // ****************************************
    // Active images
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divide_out <= '0;
        end else if (ld0) begin
            divide_out.whole_divide <= word[R0_WHOLE_LO +: 16];
            divide_out.channel_numerator <= word[F_LO +: 12];
        end
    end

    // High in the cycle in which the register 0 write and its buffered fields show
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divide_update <= 1'b0;
        end else begin
            divide_update <= ld0;
        end
    end

    // Unbuffered bits follow their own write; buffered bits wait for register 0
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_out <= '0;
        end else begin
            if (ld1) begin
                phase_out.phase_adjust_enable <= word[R1_PHADJ];
                phase_out.prescaler_select <= word[R1_PRESC];
            end
            if (ld0) begin
                phase_out.phase_word <= phase_pend_q.phase_word;
                phase_out.channel_denominator <= phase_pend_q.channel_denominator;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            refctl_out <= '0;
        end else begin
            if (ld2) begin
                refctl_out.noise_mode <= word[R2_NOISE_LO +: 2];
                refctl_out.mux_select <= word[R2_MUX_LO +: 3];
                refctl_out.divider_dbuf_enable <= word[R2_DBB_EN];
                refctl_out.lock_cycle_count_select <= word[R2_LDCNT];
                refctl_out.lock_window_select <= word[R2_LDWIN];
                refctl_out.pd_polarity <= word[R2_POL];
                refctl_out.power_down <= word[R2_PD];
                refctl_out.cp_three_state <= word[R2_CP3S];
                refctl_out.counter_reset <= word[R2_CRST];
            end
            if (ld0) begin
                refctl_out.ref_doubler <= ref_pend_q.ref_doubler;
                refctl_out.reference_halver <= ref_pend_q.reference_halver;
                refctl_out.ref_counter <= ref_pend_q.ref_counter;
                refctl_out.cp_current <= ref_pend_q.cp_current;
            end
        end
    end

    // ****************************************
    // Immediate images (output divider select waits for register 0 while buffered)
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bandclk_out <= '0;
        end else if (ld3) begin
            bandclk_out.band_clock_mode <= word[R3_BSMODE];
            bandclk_out.antibacklash_width_select <= word[R3_ABP];
            bandclk_out.charge_cancel <= word[R3_CCAN];
            bandclk_out.slip_reduction_enable <= word[R3_CSLIP];
            bandclk_out.clk_div_mode <= word[R3_CDM_LO +: 2];
            bandclk_out.clk_div_value <= word[F_LO +: 12];
        end
    end

    // Buffer enable is taken from the active register 2 value
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            outctl_out <= '0;
        end else begin
            if (ld4) begin
                outctl_out.feedback_select <= word[R4_FB];
                outctl_out.band_clk_div <= word[R4_BSDIV_LO +: 8];
                outctl_out.vco_power_down <= word[R4_VCOPD];
                outctl_out.mute_until_locked <= word[R4_MUTE];
                outctl_out.aux_select <= word[R4_AUXSEL];
                outctl_out.aux_enable <= word[R4_AUXEN];
                outctl_out.aux_power <= word[R4_AUXPW_LO +: 2];
                outctl_out.out_enable <= word[R4_OUTEN];
                outctl_out.out_power <= word[F_LO +: 2];
                if (!refctl_out.divider_dbuf_enable) begin
                    outctl_out.out_div_select <= word[R4_ODIV_LO +: 3];
                end
            end else if (ld0 && refctl_out.divider_dbuf_enable) begin
                outctl_out.out_div_select <= odiv_pend_q;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lockpin_out <= '0;
        end else if (ld5) begin
            lockpin_out.lock_pin_mode <= word[R5_LOCK_LO +: 2];
        end
    end
endmodule // synth_serial_register_map
`default_nettype wire

// >>> rtl/synth_reg_pkg.sv
package synth_reg_pkg;

    // ****************************************
    // Word framing
    // ****************************************
    localparam int WORD_W = 32;
    localparam int SEL_W = 3;
    localparam logic [2:0] SEL_R0 = 3'h0;
    localparam logic [2:0] SEL_R1 = 3'h1;
    localparam logic [2:0] SEL_R2 = 3'h2;
    localparam logic [2:0] SEL_R3 = 3'h3;
    localparam logic [2:0] SEL_R4 = 3'h4;
    localparam logic [2:0] SEL_R5 = 3'h5;

    // ****************************************
    // Field positions (low bit of each field)
    // ****************************************
    localparam int F_LO = 3;
    localparam int R0_WHOLE_LO = 15;
    localparam int R1_PHADJ = 28;
    localparam int R1_PRESC = 27;
    localparam int R1_PHASE_LO = 15;
    localparam int R2_NOISE_LO = 29;
    localparam int R2_MUX_LO = 26;
    localparam int R2_DBL = 25;
    localparam int R2_HALF = 24;
    localparam int R2_RCNT_LO = 14;
    localparam int R2_DBB_EN = 13;
    localparam int R2_CP_LO = 9;
    localparam int R2_LDCNT = 8;
    localparam int R2_LDWIN = 7;
    localparam int R2_POL = 6;
    localparam int R2_PD = 5;
    localparam int R2_CP3S = 4;
    localparam int R2_CRST = 3;
    localparam int R3_BSMODE = 23;
    localparam int R3_ABP = 22;
    localparam int R3_CCAN = 21;
    localparam int R3_CSLIP = 18;
    localparam int R3_CDM_LO = 15;
    localparam int R4_FB = 23;
    localparam int R4_ODIV_LO = 20;
    localparam int R4_BSDIV_LO = 12;
    localparam int R4_VCOPD = 11;
    localparam int R4_MUTE = 10;
    localparam int R4_AUXSEL = 9;
    localparam int R4_AUXEN = 8;
    localparam int R4_AUXPW_LO = 6;
    localparam int R4_OUTEN = 5;
    localparam int R5_LOCK_LO = 22;

    // ****************************************
    // Decoded register images
    // ****************************************
    typedef struct packed {
        logic [15:0] whole_divide;
        logic [11:0] channel_numerator;
    } divide_s;

    typedef struct packed {
        logic phase_adjust_enable;
        logic prescaler_select;
        logic [11:0] phase_word;
        logic [11:0] channel_denominator;
    } phase_s;

    typedef struct packed {
        logic [1:0] noise_mode;
        logic [2:0] mux_select;
        logic ref_doubler;
        logic reference_halver;
        logic [9:0] ref_counter;
        logic divider_dbuf_enable;
        logic [3:0] cp_current;
        logic lock_cycle_count_select;
        logic lock_window_select;
        logic pd_polarity;
        logic power_down;
        logic cp_three_state;
        logic counter_reset;
    } refctl_s;

    typedef struct packed {
        logic band_clock_mode;
        logic antibacklash_width_select;
        logic charge_cancel;
        logic slip_reduction_enable;
        logic [1:0] clk_div_mode;
        logic [11:0] clk_div_value;
    } bandclk_s;

    typedef struct packed {
        logic feedback_select;
        logic [2:0] out_div_select;
        logic [7:0] band_clk_div;
        logic vco_power_down;
        logic mute_until_locked;
        logic aux_select;
        logic aux_enable;
        logic [1:0] aux_power;
        logic out_enable;
        logic [1:0] out_power;
    } outctl_s;

    typedef struct packed {
        logic [1:0] lock_pin_mode;
    } lockpin_s;

endpackage

// >>> rtl/synth_serial_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module synth_serial_shifter
    import synth_reg_pkg::*;
#(
    parameter int W = WORD_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic load_strobe,
    output logic [W-1:0] word,
    output logic word_load
);
    // ****************************************
    // Pin synchronisers and edge detect
    // ****************************************
    logic [2:0] clk_s_q, data_s_q, load_s_q;
    logic [W-1:0] shift_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_s_q <= '0;
            data_s_q <= '0;
            load_s_q <= '0;
        end else begin
            clk_s_q <= {clk_s_q[1:0], ser_clk};
            data_s_q <= {data_s_q[1:0], ser_data};
            load_s_q <= {load_s_q[1:0], load_strobe};
        end
    end

    // Data is delayed one stage more than the clock so it is read before any late change
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= '0;
        end else if (clk_s_q[1] && !clk_s_q[2]) begin
            shift_q <= {shift_q[W-2:0], data_s_q[2]};
        end
    end

    assign word = shift_q;
    assign word_load = load_s_q[1] && !load_s_q[2];
endmodule // synth_serial_shifter
`default_nettype wire

// >>> verif/synth_serial_register_map_checker.sv
`timescale 1ns/1ps
`default_nettype none
module synth_serial_register_map_checker
    import synth_reg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic load_strobe,
    input wire divide_s divide_out,
    input wire phase_s phase_out,
    input wire refctl_s refctl_out,
    input wire bandclk_s bandclk_out,
    input wire outctl_s outctl_out,
    input wire lockpin_s lockpin_out,
    input wire logic divide_update
);
    // ****************************************
    // Age of the last load strobe rise, saturating so idle runs stay quiet
    // ****************************************
    logic ls_q;
    logic [3:0] age_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ls_q <= 1'b0;
            age_q <= 4'hf;
        end else begin
            ls_q <= load_strobe;
            if (load_strobe && !ls_q) begin
                age_q <= 4'h0;
            end else if (age_q != 4'hf) begin
                age_q <= age_q + 4'h1;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_divide_only_load: assert property ($changed(divide_out) |-> age_q <= 4'h8)
        else $error("divide register moved without a load");
    a_others_only_load: assert property ($changed({phase_out, refctl_out, bandclk_out,
        outctl_out, lockpin_out}) |-> age_q <= 4'h8)
        else $error("register image moved without a load");
    a_update_after_load: assert property (divide_update |-> age_q >= 4'h1 && age_q <= 4'h8)
        else $error("divide update pulse not tied to a load");
    a_update_one_cycle: assert property (divide_update |=> !divide_update [*8])
        else $error("divide update pulse too long");
    a_phase_buffered: assert property ($changed({phase_out.phase_word,
        phase_out.channel_denominator}) |-> divide_update)
        else $error("buffered phase fields applied without divide write");
    a_ref_buffered: assert property ($changed({refctl_out.ref_doubler, refctl_out.reference_halver,
        refctl_out.ref_counter, refctl_out.cp_current}) |-> divide_update)
        else $error("buffered reference fields applied without divide write");
    a_odiv_buffered: assert property ($changed(outctl_out.out_div_select)
        && $past(refctl_out.divider_dbuf_enable) |-> divide_update)
        else $error("output divider applied early while buffering");
    a_reset_zero: assert property ($rose(rst_b) |-> divide_out == '0 && phase_out == '0
        && refctl_out == '0 && outctl_out == '0 && bandclk_out == '0
        && lockpin_out == '0 && !divide_update)
        else $error("outputs not cleared by reset");
endmodule // synth_serial_register_map_checker
bind synth_serial_register_map synth_serial_register_map_checker i_chk (.ref_clk(ref_clk),
    .rst_b(rst_b), .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe),
    .divide_out(divide_out), .phase_out(phase_out), .refctl_out(refctl_out),
    .bandclk_out(bandclk_out), .outctl_out(outctl_out), .lockpin_out(lockpin_out),
    .divide_update(divide_update));
`default_nettype wire

// >>> verif/synth_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module synth_host_model (
    input wire logic ref_clk,
    output logic ser_clk,
    output logic ser_data,
    output logic load_strobe
);
    // ****************************************
    // Three-wire host, all pins move on the falling system edge
    // ****************************************
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            ser_data = w[i];
            hold(4);
            ser_clk = 1'b1;
            hold(4);
            ser_clk = 1'b0;
        end
        // Data no longer valid: show the inverse so a late sample is caught
        ser_data = ~ser_data;
        hold(4);
        load_strobe = 1'b1;
        hold(4);
        load_strobe = 1'b0;
    endtask
endmodule // synth_host_model
`default_nettype wire

// >>> verif/test_synth_serial_register_map.sv
`timescale 1ns/1ps
`default_nettype none
module test_synth_serial_register_map
    import synth_reg_pkg::*;
();
    logic ref_clk, rst_b, ser_clk, ser_data, load_strobe, divide_update;
    divide_s divide_out, e_div;
    phase_s phase_out, e_ph;
    refctl_s refctl_out, e_ref;
    bandclk_s bandclk_out, e_bc;
    outctl_s outctl_out, e_out;
    lockpin_s lockpin_out, e_lp;
    logic [23:0] p_ph;
    logic [15:0] p_ref;
    logic [2:0] p_od;
    int n_mismatch, tests_run;
    int n_upd = 0;
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    synth_serial_register_map i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .ser_clk(ser_clk),
        .ser_data(ser_data), .load_strobe(load_strobe), .divide_out(divide_out),
        .phase_out(phase_out), .refctl_out(refctl_out), .bandclk_out(bandclk_out),
        .outctl_out(outctl_out), .lockpin_out(lockpin_out), .divide_update(divide_update));
    synth_host_model i_host (.ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data),
        .load_strobe(load_strobe));
    always @(posedge ref_clk) begin
        if (divide_update === 1'b1) n_upd <= n_upd + 1;
    end
    // ****************************************
    // Checking and closing
    // ****************************************
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        $display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task check_all(input int upd);
        check("divide_out", 32'(divide_out), 32'(e_div));
        check("phase_out", 32'(phase_out), 32'(e_ph));
        check("refctl_out", 32'(refctl_out), 32'(e_ref));
        check("bandclk_out", 32'(bandclk_out), 32'(e_bc));
        check("outctl_out", 32'(outctl_out), 32'(e_out));
        check("lockpin_out", 32'(lockpin_out), 32'(e_lp));
        check("divide_update", 32'(n_upd), 32'(upd));
    endtask
    // Expected images follow the field map; pending copies wait for a divide write
    task write_reg(input logic [31:0] w);
        int u0;
        u0 = n_upd;
        i_host.send(w);
        repeat (12) @(negedge ref_clk);
        case (w[2:0])
            SEL_R0: begin
                e_div = w[30:3];
                {e_ph.phase_word, e_ph.channel_denominator} = p_ph;
                {e_ref.ref_doubler, e_ref.reference_halver, e_ref.ref_counter,
                    e_ref.cp_current} = p_ref;
                if (e_ref.divider_dbuf_enable) e_out.out_div_select = p_od;
            end
            SEL_R1: begin
                {e_ph.phase_adjust_enable, e_ph.prescaler_select} = w[28:27];
                p_ph = w[26:3];
            end
            SEL_R2: begin
                p_ref = {w[25:14], w[12:9]};
                e_ref = {w[30:26], e_ref.ref_doubler, e_ref.reference_halver, e_ref.ref_counter,
                    w[13], e_ref.cp_current, w[8:3]};
            end
            SEL_R3: e_bc = {w[23:21], w[18], w[16:3]};
            SEL_R4: begin
                p_od = w[22:20];
                e_out = {w[23], e_ref.divider_dbuf_enable ? e_out.out_div_select : w[22:20], w[19:3]};
            end
            SEL_R5: e_lp = w[23:22];
            default: ;
        endcase
        check_all(u0 + int'(w[2:0] == SEL_R0));
    endtask
    initial begin
        #500000;
        n_mismatch++;
        give_verdict;
    end
    initial begin
        rst_b = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        {e_div, e_ph, e_ref, e_bc, e_out, e_lp, p_ph, p_ref, p_od} = '0;
        repeat (3) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        check_all(0);
        // Power-up order, top register first
        write_reg(32'h0098_0005);
        write_reg(32'h00DA_56F4);
        write_reg(32'h00A5_55E3);
        write_reg(32'h7A80_736A);
        write_reg(32'h1000_8321);
        write_reg(32'h000B_8318);
        // New buffered values stay pending across ignored words
        write_reg(32'h0FFF_7FF9);
        write_reg(32'h2100_6C92);
        write_reg(32'h002A_56F4);
        write_reg(32'hFFFF_FFFE);
        write_reg(32'h1234_5677);
        write_reg(32'h0025_FFF0);
        write_reg(32'h7FFF_8000);
        write_reg(32'h2100_4C92);
        write_reg(32'h007A_56F4);
        give_verdict;
    end
endmodule // test_synth_serial_register_map
`default_nettype wire
